// ==== hdl/lbr_ram.sv ====
`timescale 1ns/1ps
`default_nettype none

module lbr_ram
    import lbr_pkg::*;
(
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       master_clk_i,
    input  wire logic                       chip_enable_n_i,
    input  wire logic                       read_strobe_cmd_i,
    input  wire logic                       write_strobe_cmd_i,
    input  wire logic [lbr_pkg::WORD_W-1:0] shared_io_bus_i,
    output logic      [lbr_pkg::WORD_W-1:0] shared_io_bus_o,
    output logic      [lbr_pkg::WORD_W-1:0] shared_io_bus_oe_o
);
    import lbr_pkg::*;

    // =========================================================
    // Elaboration checks
    // =========================================================
    // One set of bus lines carries both address and data
    if (ADDR_W != WORD_W)
    begin : g_bad_bus_width
        $error("lbr_ram: address and data widths must match");
    end

    // Every latched address must name a stored word
    if (DEPTH != (1 << ADDR_W))
    begin : g_bad_depth
        $error("lbr_ram: depth must cover every address");
    end

    // The address after reset must name a stored word
    if (ADDR_RST >= DEPTH)
    begin : g_bad_addr_rst
        $error("lbr_ram: reset address outside the store");
    end

    // =========================================================
    // Pin synchronisers
    // =========================================================
    logic [3:0]        ctl_s1_q;
    logic [3:0]        ctl_s2_q;
    logic [WORD_W-1:0] bus_s1_q;
    logic [WORD_W-1:0] bus_s2_q;
    logic              mclk_pin_d1_q;

    // Control lines idle high: master clock high, all strobes inactive
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl_s1_q <= '1;
            ctl_s2_q <= '1;
        end
        else
        begin
            ctl_s1_q <= {master_clk_i, chip_enable_n_i, read_strobe_cmd_i, write_strobe_cmd_i};
            ctl_s2_q <= ctl_s1_q;
        end
    end

    // Same depth as the controls, so address and data stay aligned with them
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bus_s1_q <= DATA_RST;
            bus_s2_q <= DATA_RST;
        end
        else
        begin
            bus_s1_q <= shared_io_bus_i;
            bus_s2_q <= bus_s1_q;
        end
    end

    // Only the second stage feeds logic
    logic mclk_s;
    logic enable_n_s;
    logic read_s;
    logic write_s;

    assign mclk_s     = ctl_s2_q[3];
    assign enable_n_s = ctl_s2_q[2];
    assign read_s     = ctl_s2_q[1];
    assign write_s    = ctl_s2_q[0];

    // =========================================================
    // Master clock fall detect
    // =========================================================
    // Preset high like the idle pin, so leaving reset is not seen as a fall
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            mclk_pin_d1_q <= 1'b1;
        else
            mclk_pin_d1_q <= mclk_s;
    end

    logic mclk_fall;
    assign mclk_fall = mclk_pin_d1_q & ~mclk_s;

    // =========================================================
    // Command view
    // =========================================================
    // Enable and both strobes are active low
    logic selected;
    logic read_req;
    logic write_req;
    logic both_idle;

    assign selected  = !enable_n_s;
    assign read_req  = !read_s;
    assign write_req = !write_s;
    assign both_idle = read_s && write_s;

    // =========================================================
    // Access decode at master clock fall
    // =========================================================
    lbr_acc_type acc_d;

    // Write wins at a fall; any other selected fall takes a new address
    always_comb
    begin
        acc_d = ACC_IDLE;
        if (mclk_fall && selected)
        begin
            if (write_req)
                acc_d = ACC_WRITE;
            else if (both_idle)
                acc_d = ACC_UNDEF;
            else
                acc_d = ACC_ADDR;
        end
    end

    // =========================================================
    // Address latch
    // =========================================================
    logic [ADDR_W-1:0] addr_q;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            addr_q <= ADDR_RST;
        else
        begin
            case (acc_d)
                // No write here, and no drive at ACC_UNDEF, but the address still moves
                ACC_ADDR,
                ACC_UNDEF: addr_q <= bus_s2_q;
                ACC_IDLE,
                ACC_WRITE: addr_q <= addr_q;
                default:   addr_q <= addr_q;
            endcase
        end
    end

    // =========================================================
    // Storage
    // =========================================================
    lbr_mem_if mem_bus ();

    // A write lands one system clock after the fall; read data trails the address likewise
    logic store_we;

    assign store_we      = (acc_d == ACC_WRITE);
    assign mem_bus.we    = store_we;
    assign mem_bus.addr  = addr_q;
    assign mem_bus.wdata = bus_s2_q;

    // Store depth follows the address width
    lbr_store #(
        .DEPTH_P (DEPTH)
    ) u_store (
        .mclk_i  (mclk_i),
        .port_if (mem_bus.mem)
    );

    // =========================================================
    // Three-state output drive
    // =========================================================
    // Drive needs enable and read low with write high
    logic              drive_d;
    logic [WORD_W-1:0] drive_word;

    assign drive_d    = selected && read_req && !write_req;
    assign drive_word = drive_d ? mem_bus.rdata : DATA_RST;

    // Lines read as zero whenever the enables are off
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            shared_io_bus_o <= DATA_RST;
        else
            shared_io_bus_o <= drive_word;
    end

    // All enable bits move together; enable or read going high, or write going low, releases the lines
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            shared_io_bus_oe_o <= '0;
        else
            shared_io_bus_oe_o <= {WORD_W{drive_d}};
    end

endmodule : lbr_ram

`default_nettype wire

// ==== include/lbr_pkg.sv ====
`default_nettype none

package lbr_pkg;

    // =========================================================
    // Geometry
    // =========================================================
    localparam int unsigned WORD_W  = 8;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DEPTH   = 256;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [WORD_W-1:0] DATA_RST = 8'h00;

    // =========================================================
    // Bus access decode
    // =========================================================
    typedef enum logic [3:0]
    {
        ACC_IDLE  = 4'b0001,
        ACC_ADDR  = 4'b0010,
        ACC_WRITE = 4'b0100,
        ACC_UNDEF = 4'b1000
    } lbr_acc_type;

endpackage : lbr_pkg

`default_nettype wire

// ==== include/lbr_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface lbr_mem_if;
    logic                      we;
    logic [lbr_pkg::ADDR_W-1:0] addr;
    logic [lbr_pkg::WORD_W-1:0] wdata;
    logic [lbr_pkg::WORD_W-1:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface : lbr_mem_if

`default_nettype wire

// ==== hdl/lbr_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module lbr_store
    import lbr_pkg::*;
#(
    parameter int unsigned DEPTH_P = lbr_pkg::DEPTH
)
(
    input  wire logic mclk_i,
    lbr_mem_if.mem    port_if
);
    import lbr_pkg::*;

    if (DEPTH_P != (1 << ADDR_W))
    begin : g_bad_depth
        $error("lbr_store: depth must match address width");
    end

    // =========================================================
    // Storage array, read data registered
    // =========================================================
    logic [WORD_W-1:0] mem_q [DEPTH_P];
    logic [WORD_W-1:0] rdata_q;

    always_ff @(posedge mclk_i)
    begin
        if (port_if.we)
            mem_q[port_if.addr] <= port_if.wdata;
    end

    always_ff @(posedge mclk_i)
    begin
        rdata_q <= mem_q[port_if.addr];
    end

    assign port_if.rdata = rdata_q;

endmodule : lbr_store

`default_nettype wire

// ==== tb/lbr_ram_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module lbr_ram_asserts (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       master_clk_i,
    input wire logic       chip_enable_n_i,
    input wire logic       read_strobe_cmd_i,
    input wire logic       write_strobe_cmd_i,
    input wire logic [7:0] shared_io_bus_i,
    input wire logic [7:0] shared_io_bus_o,
    input wire logic [7:0] shared_io_bus_oe_o
);
    // ========
    // Pin checks
    wire       rd = read_strobe_cmd_i;
    wire       wr = write_strobe_cmd_i;
    wire       ce = chip_enable_n_i;
    wire [7:0] oe = shared_io_bus_oe_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd; (!rd && !ce && wr)[*6]; endsequence
    sequence s_wr; (!wr)[*5]; endsequence
    AST_OE_EQ: assert property (oe == 8'h00 || oe == 8'hFF)
        else $error("oe bits differ");
    AST_IDLE_LOW: assert property (oe == 8'h00 |-> shared_io_bus_o == 8'h00)
        else $error("data out while released");
    AST_READ_DRV: assert property (s_rd |-> oe == 8'hFF)
        else $error("read not driven");
    AST_READ_HOLD: assert property (s_rd ##1 (!rd && !ce && wr) |-> $stable(shared_io_bus_o))
        else $error("read word changed");
    AST_RD_OFF: assert property (rd[*5] |-> oe == 8'h00)
        else $error("drive after read high");
    AST_CE_OFF: assert property (ce[*5] |-> oe == 8'h00)
        else $error("drive after enable high");
    AST_UNDEF: assert property ((rd && wr)[*5] |-> oe == 8'h00)
        else $error("drive with both commands high");
    AST_WR_QUIET: assert property (s_wr |-> oe == 8'h00)
        else $error("drive during write");
endmodule : lbr_ram_asserts

bind lbr_ram lbr_ram_asserts chk_u (.mclk_i, .rst_i, .master_clk_i, .chip_enable_n_i,
    .read_strobe_cmd_i, .write_strobe_cmd_i, .shared_io_bus_i, .shared_io_bus_o, .shared_io_bus_oe_o);

`default_nettype wire

// ==== tb/lbr_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module lbr_host (
    input  wire logic  mclk_i,
    output logic       mck_o,
    output logic       ce_n_o,
    output logic       rd_o,
    output logic       wr_o,
    output logic [7:0] bus_o,
    output logic       drv_o
);
    // ========
    // Host bus cycles
    initial {mck_o, ce_n_o, rd_o, wr_o, drv_o, bus_o} = 13'h1E00;
    // Pins stand 3 cycles before each clock fall and 3 cycles after the rise
    task automatic fall(input logic [7:0] v, input logic w, input logic c);
        @(negedge mclk_i);
        bus_o = v;
        drv_o = 1'b1;
        ce_n_o = c;
        wr_o = w;
        repeat (3) @(negedge mclk_i);
        mck_o = 1'b0;
        repeat (3) @(negedge mclk_i);
        mck_o = 1'b1;
        repeat (3) @(negedge mclk_i);
        wr_o = 1'b1;
        ce_n_o = 1'b1;
        drv_o = 1'b0;
    endtask : fall
    task automatic hold(input logic r, input logic c, input int n);
        @(negedge mclk_i);
        rd_o = r;
        ce_n_o = c;
        repeat (n) @(negedge mclk_i);
    endtask : hold
endmodule : lbr_host

`default_nettype wire

// ==== tb/latched_bus_ram_256x8_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module latched_bus_ram_256x8_bench;
    import lbr_pkg::*;
    // ========
    // Bench
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       mck, ce, rd, wr, drv;
    logic [7:0] hb, bus_o, oe, bus;
    int         n_errors = 0;
    int         n_tests = 0;
    int         cyc = 0;
    always #5 mclk_i = ~mclk_i;
    // Released host lines show the inverse
    assign bus = oe[0] ? bus_o : (drv ? hb : ~hb);
    lbr_ram dut_u (.mclk_i, .rst_i, .master_clk_i(mck), .chip_enable_n_i(ce),
        .read_strobe_cmd_i(rd), .write_strobe_cmd_i(wr), .shared_io_bus_i(bus),
        .shared_io_bus_o(bus_o), .shared_io_bus_oe_o(oe));
    lbr_host host_u (.mclk_i, .mck_o(mck), .ce_n_o(ce), .rd_o(rd), .wr_o(wr), .bus_o(hb), .drv_o(drv));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_do(input logic [7:0] a, input logic [7:0] d, input logic c);
        host_u.fall(a, 1'b1, 1'b0);
        host_u.fall(d, 1'b0, c);
    endtask : wr_do
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic c);
        host_u.fall(a, 1'b1, 1'b0);
        host_u.hold(1'b0, c, 6);
        chk("rdata", bus_o, c ? 8'h00 : e);
        chk("oe", oe, c ? 8'h00 : 8'hFF);
        host_u.hold(1'b1, 1'b1, 5);
        chk("oe_off", oe, 8'h00);
    endtask : rd_chk
    task automatic t_rw();
        wr_do(8'h00, 8'h5A, 1'b0);
        wr_do(8'hFF, 8'hA5, 1'b0);
        rd_chk(8'h00, 8'h5A, 1'b0);
        rd_chk(8'hFF, 8'hA5, 1'b0);
    endtask : t_rw
    task automatic t_refuse();
        wr_do(8'hFF, 8'h3C, 1'b1);
        rd_chk(8'hFF, 8'hA5, 1'b0);
        rd_chk(8'h00, 8'h5A, 1'b1);
        wr_do(8'h00, 8'hC3, 1'b0);
        rd_chk(8'h00, 8'hC3, 1'b0);
    endtask : t_refuse
    task automatic complete_run();
        $display("Checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (5) @(negedge mclk_i);
        rst_i = 1'b0;
        host_u.hold(1'b1, 1'b1, 3);
        t_rw();
        t_refuse();
        complete_run();
    end
endmodule : latched_bus_ram_256x8_bench

`default_nettype wire
